// ===== design/epaper_panel_command_decoder.sv
// Serial command decoder of the e-paper panel driver
// How it works
// (RULE_01) Select low marks opcodes, high marks params
// (RULE_02) 00h first param: resolution, table, scan bits; 0Fh
// (RULE_03) Second panel param keeps bit 4, VCOM float; 00h
// (RULE_04) 01h: supply enables 07h, 2-bit gate level 01h
// (RULE_05) Third, fourth power params: 6-bit source levels, 05h
// (RULE_06) 02h pulses supply power-off
// (RULE_07) 03h param bits 5:4 set source-off delay, 00h
// (RULE_08) 04h pulses supply power-on
// (RULE_09) 06h: booster phases A, B 8 bits, C 6 bits, 00h
// (RULE_10) 07h sleeps only after check byte A5h
// (RULE_11) After 10h each param gives two 3-bit pixel codes
// (RULE_12) 11h ends image data; next read gives flag in bit 7
// (RULE_13) 12h pulses display refresh
// (RULE_14) 13h: bit 4 enables processing, bits 2:0 select it
// (RULE_15) 20h loads 220 VCOM table bytes
// (RULE_16) 21h loads 260 blue table bytes
// (RULE_17) 22h loads 260 white table bytes
// (RULE_18) Host issues nothing while busy is low
// (RULE_19) Bus select low: 8-bit frames; high: 9-bit frames
// (RULE_20) Transfers only while selected; reset pin restores defaults
// (RULE_21) Unused bits ignored; unwritten params keep defaults
// (RULE_22) Surplus params ignored until next opcode
`timescale 1ns/100ps
module epaper_panel_command_decoder #(
  parameter int FIFO_DEPTH = panel_cmd_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link pins; inputs asynchronous to ref_clk, outputs registered on it
  input wire logic reset_n_pin,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dc_sel,
  input wire logic bus_width_select,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  output logic busy_n,
  // Waveform engine status
  input wire logic engine_busy,
  // Stored configuration
  output logic [7:0] panel_config,
  output logic [7:0] panel_vcom_float,
  output logic [7:0] supply_enables,
  output logic [7:0] gate_level,
  output logic [7:0] positive_source_level,
  output logic [7:0] negative_source_level,
  output logic [7:0] poweroff_delay,
  output logic [7:0] booster_phase_a,
  output logic [7:0] booster_phase_b,
  output logic [7:0] booster_phase_c,
  output logic [7:0] image_process_ctrl,
  // Events and sleep level
  output logic supply_off_start,
  output logic supply_on_start,
  output logic refresh_start,
  output logic deep_sleep,
  // Waveform table write port
  output logic table_wr,
  output logic [1:0] table_sel,
  output logic [8:0] table_addr,
  output logic [7:0] table_data,
  // Pixel pair stream out of the FIFO
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [5:0] pix_pair
);

  panel_cmd_pkg::dec_st_t st_r;
  panel_cmd_pkg::dec_st_t st_nxt;

  pix_stream_if #(.WIDTH(panel_cmd_pkg::PIX_WIDTH)) pix_s ();

  ////////////////////////////////////////////////////////////////////////////
  // Defaults of every control field after either reset
  function automatic panel_cmd_pkg::dec_st_t load_defaults(
    input panel_cmd_pkg::dec_st_t s);
    panel_cmd_pkg::dec_st_t d;
    // Synchronisers keep tracking the pins; all else takes its reset value
    d = '0;
    d.sclk_s = s.sclk_s;
    d.cs_s = s.cs_s;
    d.dc_s = s.dc_s;
    d.din_s = s.din_s;
    d.bs_s = s.bs_s;
    d.rst_s = s.rst_s;
    d.sclk_d = s.sclk_d;
    d.busy_n = 1'b1;
    d.st = panel_cmd_pkg::ST_IDLE;
    d.panel_config = panel_cmd_pkg::RST_PANEL_CONFIG; // RULE_02
    d.vcom_float = panel_cmd_pkg::RST_VCOM_FLOAT; // RULE_03
    d.supply_en = panel_cmd_pkg::RST_SUPPLY_ENABLES; // RULE_04
    d.gate_level = panel_cmd_pkg::RST_GATE_LEVEL; // RULE_04
    d.pos_level = panel_cmd_pkg::RST_POS_SRC_LEVEL; // RULE_05
    d.neg_level = panel_cmd_pkg::RST_NEG_SRC_LEVEL; // RULE_05
    d.off_delay = panel_cmd_pkg::RST_POWEROFF_DELAY; // RULE_07
    d.phase_a = panel_cmd_pkg::RST_BOOST_PHASE; // RULE_09
    d.phase_b = panel_cmd_pkg::RST_BOOST_PHASE;
    d.phase_c = panel_cmd_pkg::RST_BOOST_PHASE;
    d.img_proc = panel_cmd_pkg::RST_IMAGE_PROCESS; // RULE_14
    return d;
  endfunction : load_defaults

  // Table length of a table opcode, zero for any other opcode
  function automatic logic [8:0] table_len(input logic [7:0] op);
    case (op)
      panel_cmd_pkg::OP_VCOM_TABLE: table_len = panel_cmd_pkg::VCOM_TABLE_LEN;
      panel_cmd_pkg::OP_BLUE_TABLE,
      panel_cmd_pkg::OP_WHITE_TABLE: table_len = panel_cmd_pkg::COLOR_TABLE_LEN;
      default: table_len = '0;
    endcase
  endfunction : table_len

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state
  logic rise;
  logic fall;
  logic sel_active;
  logic three_wire;
  logic [3:0] frame_bits;
  logic [8:0] sh;
  logic byte_done;
  logic is_param;
  logic [7:0] rx;
  logic [3:0] rd_bit;
  logic [7:0] rd_byte;

  always_comb begin
    st_nxt = st_r;
    // Two-flop synchronisers; logic reads only the second flop
    st_nxt.sclk_s = {st_r.sclk_s[0], sclk};
    st_nxt.cs_s = {st_r.cs_s[0], cs_n};
    st_nxt.dc_s = {st_r.dc_s[0], dc_sel};
    st_nxt.din_s = {st_r.din_s[0], sdata_in};
    st_nxt.bs_s = {st_r.bs_s[0], bus_width_select};
    st_nxt.rst_s = {st_r.rst_s[0], reset_n_pin};
    st_nxt.sclk_d = st_r.sclk_s[1];
    rise = st_r.sclk_s[1] & ~st_r.sclk_d;
    fall = ~st_r.sclk_s[1] & st_r.sclk_d;
    sel_active = ~st_r.cs_s[1];
    three_wire = st_r.bs_s[1];
    frame_bits = three_wire ? panel_cmd_pkg::BITS_3WIRE
                            : panel_cmd_pkg::BITS_4WIRE; // RULE_19
    sh = {st_r.shreg[7:0], st_r.din_s[1]};
    byte_done = 1'b0;
    is_param = 1'b0;
    rx = sh[7:0];
    rd_bit = '0;
    rd_byte = {st_r.data_flag, 7'h00}; // RULE_12

    // Single-cycle outputs fall back every cycle
    st_nxt.off_go = 1'b0;
    st_nxt.on_go = 1'b0;
    st_nxt.refresh_go = 1'b0;
    st_nxt.tbl_wr = 1'b0;
    st_nxt.pix_wr = 1'b0;

    // Shift on the rising link edge; a deselect drops a partial frame
    if (!sel_active) begin
      st_nxt.bitcnt = '0; // RULE_20
    end else if (rise) begin
      st_nxt.shreg = sh;
      if (st_r.bitcnt + 4'h1 == frame_bits) begin
        st_nxt.bitcnt = '0;
        byte_done = 1'b1;
      end else begin
        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
      end
    end

    // Class of the byte: in 3-wire the leading bit carries the select
    is_param = three_wire ? sh[8] : st_r.dc_s[1]; // RULE_01 RULE_19

    // Read cycle after data stop: drive the flag byte, MSB first
    if (st_r.rd_mode && sel_active &&
        (st_r.bitcnt >= {3'h0, three_wire})) begin
      rd_bit = st_r.bitcnt - {3'h0, three_wire};
      st_nxt.sdoe = 1'b1;
      st_nxt.sdout = rd_byte[3'h7 - rd_bit[2:0]]; // RULE_12
    end else if (!st_r.rd_mode || !sel_active) begin
      st_nxt.sdoe = 1'b0;
      st_nxt.sdout = 1'b0;
    end
    if (fall && !st_r.rd_mode) begin
      st_nxt.sdoe = 1'b0;
    end

    if (byte_done && st_r.rd_mode) begin
      // The read frame is consumed here and never decoded
      st_nxt.rd_mode = 1'b0;
    end else if (byte_done && !st_r.sleep && !is_param) begin
      // Opcode byte: start a new command, close any previous one
      st_nxt.cmd = rx; // RULE_01 RULE_22
      st_nxt.idx = '0;
      st_nxt.st = panel_cmd_pkg::ST_PARAM;
      case (rx)
        panel_cmd_pkg::OP_SUPPLY_OFF: begin
          st_nxt.off_go = 1'b1; // RULE_06
          st_nxt.st = panel_cmd_pkg::ST_IDLE;
        end
        panel_cmd_pkg::OP_SUPPLY_ON: begin
          st_nxt.on_go = 1'b1; // RULE_08
          st_nxt.st = panel_cmd_pkg::ST_IDLE;
        end
        panel_cmd_pkg::OP_REFRESH: begin
          st_nxt.refresh_go = 1'b1; // RULE_13
          st_nxt.st = panel_cmd_pkg::ST_IDLE;
        end
        panel_cmd_pkg::OP_DEEP_SLEEP: begin
          st_nxt.st = panel_cmd_pkg::ST_SLEEP; // RULE_10
        end
        panel_cmd_pkg::OP_IMAGE_DATA: begin
          st_nxt.data_seen = 1'b0;
          st_nxt.data_flag = 1'b0;
        end
        panel_cmd_pkg::OP_DATA_STOP: begin
          st_nxt.data_flag = st_r.data_seen; // RULE_12
          st_nxt.rd_mode = 1'b1;
          st_nxt.st = panel_cmd_pkg::ST_IDLE;
        end
        default: begin
        end
      endcase
    end else if (byte_done && !st_r.sleep) begin
      // Parameter byte; unused bits masked off, surplus bytes dropped
      unique case (st_r.st)
        panel_cmd_pkg::ST_IDLE: begin
        end
        panel_cmd_pkg::ST_SLEEP: begin
          if (rx == panel_cmd_pkg::DEEP_SLEEP_CHECK) begin
            st_nxt.sleep = 1'b1; // RULE_10
          end
          st_nxt.st = panel_cmd_pkg::ST_IDLE; // RULE_22
        end
        panel_cmd_pkg::ST_PARAM: begin
          if (st_r.idx != panel_cmd_pkg::IDX_MAX) begin
            st_nxt.idx = st_r.idx + 9'h001;
          end
          case (st_r.cmd)
            panel_cmd_pkg::OP_PANEL_CONFIG: begin
              if (st_r.idx == 9'h000) begin
                st_nxt.panel_config =
                  rx & panel_cmd_pkg::MASK_PANEL_CONFIG; // RULE_02 RULE_21
              end else if (st_r.idx == 9'h001) begin
                st_nxt.vcom_float =
                  rx & panel_cmd_pkg::MASK_VCOM_FLOAT; // RULE_03
              end
            end
            panel_cmd_pkg::OP_POWER_CONFIG: begin
              if (st_r.idx == 9'h000) begin
                st_nxt.supply_en =
                  rx & panel_cmd_pkg::MASK_SUPPLY_ENABLES; // RULE_04
              end else if (st_r.idx == 9'h001) begin
                st_nxt.gate_level =
                  rx & panel_cmd_pkg::MASK_GATE_LEVEL; // RULE_04
              end else if (st_r.idx == 9'h002) begin
                st_nxt.pos_level =
                  rx & panel_cmd_pkg::MASK_SRC_LEVEL; // RULE_05
              end else if (st_r.idx == 9'h003) begin
                st_nxt.neg_level =
                  rx & panel_cmd_pkg::MASK_SRC_LEVEL; // RULE_05
              end
            end
            panel_cmd_pkg::OP_SUPPLY_OFF_DELAY: begin
              if (st_r.idx == 9'h000) begin
                st_nxt.off_delay =
                  rx & panel_cmd_pkg::MASK_POWEROFF_DELAY; // RULE_07
              end
            end
            panel_cmd_pkg::OP_BOOSTER_SOFTSTART: begin
              if (st_r.idx == 9'h000) begin
                st_nxt.phase_a = rx; // RULE_09
              end else if (st_r.idx == 9'h001) begin
                st_nxt.phase_b = rx; // RULE_09
              end else if (st_r.idx == 9'h002) begin
                st_nxt.phase_c =
                  rx & panel_cmd_pkg::MASK_BOOST_PHASE_C; // RULE_09
              end
            end
            panel_cmd_pkg::OP_IMAGE_DATA: begin
              // Bits 7 and 3 carry nothing; a full FIFO drops the pair
              if (pix_s.in_ready) begin
                st_nxt.pix_wr = 1'b1; // RULE_11
                st_nxt.pix_data = {rx[6:4], rx[2:0]}; // RULE_11
                st_nxt.data_seen = 1'b1;
              end
            end
            panel_cmd_pkg::OP_IMAGE_PROCESS: begin
              if (st_r.idx == 9'h000) begin
                st_nxt.img_proc =
                  rx & panel_cmd_pkg::MASK_IMAGE_PROCESS; // RULE_14
              end
            end
            panel_cmd_pkg::OP_VCOM_TABLE,
            panel_cmd_pkg::OP_BLUE_TABLE,
            panel_cmd_pkg::OP_WHITE_TABLE: begin
              if (st_r.idx < table_len(st_r.cmd)) begin
                st_nxt.tbl_wr = 1'b1; // RULE_15 RULE_16 RULE_17
                st_nxt.tbl_sel = st_r.cmd[1:0];
                st_nxt.tbl_addr = st_r.idx;
                st_nxt.tbl_data = rx;
              end
            end
            default: begin
            end
          endcase
        end
      endcase
    end

    // Busy low while the engine works or the pixel FIFO has no room
    st_nxt.busy_n = ~(engine_busy | ~pix_s.in_ready); // RULE_18

    // Reset pin returns every control field to its default
    if (!st_r.rst_s[1]) begin
      st_nxt = load_defaults(st_nxt); // RULE_20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous active-low reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r <= load_defaults('0);
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel FIFO; its ready feeds the busy pin back to the host
  assign pix_s.in_valid = st_r.pix_wr;
  assign pix_s.in_data = st_r.pix_data;
  assign pix_s.out_ready = pix_ready;

  pix_fifo #(
    .WIDTH(panel_cmd_pkg::PIX_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_pix_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .s(pix_s)
  );

  // Output wiring, all from the state record or the FIFO
  assign sdata_out = st_r.sdout;
  assign sdata_oe = st_r.sdoe;
  assign busy_n = st_r.busy_n;
  assign panel_config = st_r.panel_config;
  assign panel_vcom_float = st_r.vcom_float;
  assign supply_enables = st_r.supply_en;
  assign gate_level = st_r.gate_level;
  assign positive_source_level = st_r.pos_level;
  assign negative_source_level = st_r.neg_level;
  assign poweroff_delay = st_r.off_delay;
  assign booster_phase_a = st_r.phase_a;
  assign booster_phase_b = st_r.phase_b;
  assign booster_phase_c = st_r.phase_c;
  assign image_process_ctrl = st_r.img_proc;
  assign supply_off_start = st_r.off_go;
  assign supply_on_start = st_r.on_go;
  assign refresh_start = st_r.refresh_go;
  assign deep_sleep = st_r.sleep;
  assign table_wr = st_r.tbl_wr;
  assign table_sel = st_r.tbl_sel;
  assign table_addr = st_r.tbl_addr;
  assign table_data = st_r.tbl_data;
  assign pix_valid = pix_s.out_valid;
  assign pix_pair = pix_s.out_data;
endmodule : epaper_panel_command_decoder

// ===== design/panel_cmd_pkg.sv
// Opcodes, defaults, field masks and counts of the panel command decoder
package panel_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] OP_PANEL_CONFIG = 8'h00;
  localparam logic [7:0] OP_POWER_CONFIG = 8'h01;
  localparam logic [7:0] OP_SUPPLY_OFF = 8'h02;
  localparam logic [7:0] OP_SUPPLY_OFF_DELAY = 8'h03;
  localparam logic [7:0] OP_SUPPLY_ON = 8'h04;
  localparam logic [7:0] OP_BOOSTER_SOFTSTART = 8'h06;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'h07;
  localparam logic [7:0] OP_IMAGE_DATA = 8'h10;
  localparam logic [7:0] OP_DATA_STOP = 8'h11;
  localparam logic [7:0] OP_REFRESH = 8'h12;
  localparam logic [7:0] OP_IMAGE_PROCESS = 8'h13;
  localparam logic [7:0] OP_VCOM_TABLE = 8'h20;
  localparam logic [7:0] OP_BLUE_TABLE = 8'h21;
  localparam logic [7:0] OP_WHITE_TABLE = 8'h22;
  localparam logic [7:0] DEEP_SLEEP_CHECK = 8'ha5;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] RST_PANEL_CONFIG = 8'h0f;
  localparam logic [7:0] RST_VCOM_FLOAT = 8'h00;
  localparam logic [7:0] RST_SUPPLY_ENABLES = 8'h07;
  localparam logic [7:0] RST_GATE_LEVEL = 8'h01;
  localparam logic [7:0] RST_POS_SRC_LEVEL = 8'h05;
  localparam logic [7:0] RST_NEG_SRC_LEVEL = 8'h05;
  localparam logic [7:0] RST_POWEROFF_DELAY = 8'h00;
  localparam logic [7:0] RST_BOOST_PHASE = 8'h00;
  localparam logic [7:0] RST_IMAGE_PROCESS = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Masks of the bits each parameter byte really holds
  localparam logic [7:0] MASK_PANEL_CONFIG = 8'hef;
  localparam logic [7:0] MASK_VCOM_FLOAT = 8'h10;
  localparam logic [7:0] MASK_SUPPLY_ENABLES = 8'h37;
  localparam logic [7:0] MASK_GATE_LEVEL = 8'h03;
  localparam logic [7:0] MASK_SRC_LEVEL = 8'h3f;
  localparam logic [7:0] MASK_POWEROFF_DELAY = 8'h30;
  localparam logic [7:0] MASK_BOOST_PHASE_C = 8'h3f;
  localparam logic [7:0] MASK_IMAGE_PROCESS = 8'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Serial framing and table lengths (parameter bytes, opcode excluded)
  localparam logic [3:0] BITS_4WIRE = 4'h8;
  localparam logic [3:0] BITS_3WIRE = 4'h9;
  localparam logic [8:0] VCOM_TABLE_LEN = 9'h0dc;
  localparam logic [8:0] COLOR_TABLE_LEN = 9'h104;
  localparam logic [8:0] IDX_MAX = 9'h1ff;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int PIX_WIDTH = 6;

  // Table selector codes on the table write port
  localparam logic [1:0] TBL_VCOM = 2'h0;
  localparam logic [1:0] TBL_BLUE = 2'h1;
  localparam logic [1:0] TBL_WHITE = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PARAM = 2'b01,
    ST_SLEEP = 2'b10
  } dec_state_t;

  // State of the whole decoder in one record
  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] dc_s;
    logic [1:0] din_s;
    logic [1:0] bs_s;
    logic [1:0] rst_s;
    logic sclk_d;
    logic [3:0] bitcnt;
    logic [8:0] shreg;
    logic rd_mode;
    logic sdout;
    logic sdoe;
    logic busy_n;
    dec_state_t st;
    logic [7:0] cmd;
    logic [8:0] idx;
    logic [7:0] panel_config;
    logic [7:0] vcom_float;
    logic [7:0] supply_en;
    logic [7:0] gate_level;
    logic [7:0] pos_level;
    logic [7:0] neg_level;
    logic [7:0] off_delay;
    logic [7:0] phase_a;
    logic [7:0] phase_b;
    logic [7:0] phase_c;
    logic [7:0] img_proc;
    logic data_seen;
    logic data_flag;
    logic sleep;
    logic off_go;
    logic on_go;
    logic refresh_go;
    logic tbl_wr;
    logic [1:0] tbl_sel;
    logic [8:0] tbl_addr;
    logic [7:0] tbl_data;
    logic pix_wr;
    logic [5:0] pix_data;
  } dec_st_t;

endpackage : panel_cmd_pkg

// ===== design/pix_stream_if.sv
// Valid/ready stream between the decoder and its pixel FIFO
`timescale 1ns/100ps
interface pix_stream_if #(parameter int WIDTH = 6);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );

  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
endinterface : pix_stream_if

// ===== design/pix_fifo.sv
// Parameterised FIFO holding pixel pairs between decoder and consumer
`timescale 1ns/100ps
module pix_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Stream ports
  pix_stream_if.fifo s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t st_r;
  fifo_st_t st_nxt;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer step that also works for depths not a power of two
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : step

  // Honest flags straight from the occupancy count
  assign s.in_ready = (st_r.cnt != (AW + 1)'(DEPTH));
  assign s.out_valid = (st_r.cnt != '0);
  assign s.out_data = st_r.mem[st_r.rp]; // Read from the register array
  assign push = s.in_valid & s.in_ready;
  assign pop = s.out_valid & s.out_ready;

  // Next state of storage and pointers
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = s.in_data;
      st_nxt.wp = step(st_r.wp);
    end
    if (pop) begin
      st_nxt.rp = step(st_r.rp);
    end
    case ({push, pop})
      2'b10: st_nxt.cnt = st_r.cnt + 1'b1;
      2'b01: st_nxt.cnt = st_r.cnt - 1'b1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  // State register, synchronous reset empties the FIFO
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : pix_fifo

// ===== verif/decoder_props.sv
// Concurrent checks on the panel command decoder ports
`timescale 1ns/100ps
module decoder_props (
  // Clock, resets and inputs
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reset_n_pin,
  input wire logic cs_n,
  input wire logic engine_busy,
  // Observed outputs
  input wire logic busy_n,
  input wire logic sdata_oe,
  input wire logic [7:0] panel_config,
  input wire logic [7:0] gate_level,
  input wire logic supply_on_start,
  input wire logic deep_sleep,
  input wire logic table_wr,
  input wire logic [1:0] table_sel,
  input wire logic [8:0] table_addr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Power-on start pulse lasts one cycle
  a_on_single: assert property (supply_on_start |=> !supply_on_start)
    else $error("power-on start too long");
  // Sleep only ends through a reset, and silences the decoder
  a_sleep_holds: assert property (deep_sleep && reset_n_pin |=> deep_sleep)
    else $error("deep sleep left without reset");
  a_sleep_quiet: assert property (deep_sleep |-> !supply_on_start && !table_wr)
    else $error("command acted on in deep sleep");
  a_reset_defaults: assert property ($rose(nrst) |-> panel_config == 8'h0f
    && gate_level == 8'h01 && !deep_sleep) else $error("bad reset values");
  a_busy_engine: assert property (engine_busy |=> !busy_n)
    else $error("busy not shown");
  // Data line released a while after deselect
  a_oe_released: assert property (cs_n [*8] |=> !sdata_oe)
    else $error("data line driven while deselected");
  a_table_range: assert property (table_wr |-> table_sel != 2'h3
    && table_addr <= (table_sel == 2'h0 ? 9'h0db : 9'h103))
    else $error("table write out of range");
  a_unused_bits: assert property ((gate_level & 8'hfc) == 8'h00)
    else $error("unused gate level bits set");
  cover property ($rose(deep_sleep));
  cover property (table_wr && table_addr == 9'h0db);
  cover property (!busy_n && !engine_busy);
endmodule : decoder_props
bind epaper_panel_command_decoder decoder_props decoder_props_inst (.*);

// ===== verif/panel_host_model.sv
// Host controller model driving the serial command link
`timescale 1ns/100ps
module panel_host_model (
  // Clock and mode
  input wire logic ref_clk,
  input wire logic bus_width_select,
  // Line driven back by the device
  input wire logic sdata_out,
  input wire logic sdata_oe,
  // Link pins
  output logic cs_n,
  output logic sclk,
  output logic dc_sel,
  output logic sdata_in
);
  // Idle link: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    dc_sel = 1'b0;
    sdata_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One frame; in 9-bit mode the D/C bit leads the byte
  task send(input logic [7:0] b, input logic dc);
    logic [8:0] f;
    f = {dc, b};
    dc_sel <= dc;
    cs_n <= 1'b0;
    for (int i = bus_width_select ? 8 : 7; i >= 0; i--) begin
      sdata_in <= f[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    // Hold select past the last edge so the byte is not dropped
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    sdata_in <= ~f[0];
    repeat (8) @(posedge ref_clk);
  endtask : send
  // Read frame; a bit the device does not drive reads as unknown
  task read(output logic [7:0] v);
    dc_sel <= 1'b1;
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (6) @(posedge ref_clk);
      v[i] = sdata_oe ? sdata_out : 1'bx;
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : read
endmodule : panel_host_model

// ===== verif/tb_epaper_panel_command_decoder.sv
// Self-checking bench of the panel command decoder
`timescale 1ns/100ps
module tb_epaper_panel_command_decoder;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic reset_n_pin = 1'b1;
  logic bus_width_select = 1'b0;
  logic engine_busy = 1'b0;
  logic pix_ready = 1'b0;
  logic cs_n, sclk, dc_sel, sdata_in, sdata_out, sdata_oe, busy_n, pix_valid;
  logic [7:0] panel_config, panel_vcom_float, supply_enables, gate_level;
  logic [7:0] positive_source_level, negative_source_level, poweroff_delay;
  logic [7:0] booster_phase_a, booster_phase_b, booster_phase_c;
  logic [7:0] image_process_ctrl, table_data, rd;
  logic supply_off_start, supply_on_start, refresh_start, deep_sleep;
  logic table_wr;
  logic [1:0] table_sel;
  logic [8:0] table_addr;
  logic [5:0] pix_pair;
  logic [7:0] q[$];
  int n_fail, checks, cyc, n_off, n_on, n_ref, n_wr;
  epaper_panel_command_decoder #(.FIFO_DEPTH(16))
    epaper_panel_command_decoder_inst (.*);
  panel_host_model panel_host_model_inst (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Event counters and hang guard
  always @(posedge ref_clk) begin
    n_off += supply_off_start;
    n_on += supply_on_start;
    n_ref += refresh_start;
    n_wr += table_wr;
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [87:0] regs();
    return {panel_config, panel_vcom_float, supply_enables, gate_level,
      positive_source_level, negative_source_level, poweroff_delay,
      booster_phase_a, booster_phase_b, booster_phase_c, image_process_ctrl};
  endfunction : regs
  task chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Opcode first, then its parameters
  task run(input logic [7:0] c[$]);
    for (int i = 0; i < c.size(); i++) begin
      panel_host_model_inst.send(c[i], i != 0);
    end
  endtask : run
  task print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("defaults", 88'h0f00070105050000000000, regs());
    run('{8'h00, 8'hff, 8'hff, 8'h77});
    run('{8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    run('{8'h03, 8'hff});
    run('{8'h06, 8'hff, 8'hff, 8'hff});
    run('{8'h13, 8'hff});
    run('{8'h01, 8'h00});
    chk("config", 88'hef1000033f3f30ffff3f17, regs());
    run('{8'h02, 8'h55});
    run('{8'h04});
    run('{8'h12});
    chk("pulses", 24'h010101, {n_off[7:0], n_on[7:0], n_ref[7:0]});
    $display("test config done");
    q = '{8'h20};
    for (int i = 0; i < 221; i++) begin
      q.push_back(i[7:0]);
    end
    run(q);
    chk("vcom", {16'd220, 2'h0, 9'h0db, 8'hdb},
      {n_wr[15:0], table_sel, table_addr, table_data});
    for (logic [7:0] c = 8'h21; c < 8'h23; c++) begin
      run('{c, 8'h5a, c});
      chk("color", {c[1:0], 9'h001, c},
        {table_sel, table_addr, table_data});
    end
    $display("test tables done");
    engine_busy <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("busy", 1'b0, busy_n);
    engine_busy <= 1'b0;
    q = '{8'h10};
    for (int i = 0; i < 16; i++) begin
      q.push_back(8'h9c);
    end
    run(q);
    chk("full", {2'b01, 6'h0c}, {busy_n, pix_valid, pix_pair});
    run('{8'h11});
    panel_host_model_inst.read(rd);
    chk("flag", 8'h80, rd);
    pix_ready <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("drained", 2'b10, {busy_n, pix_valid});
    run('{8'h10});
    run('{8'h11});
    panel_host_model_inst.read(rd);
    chk("no flag", 8'h00, rd);
    $display("test pixels done");
    run('{8'h07, 8'h00});
    chk("no sleep", 1'b0, deep_sleep);
    run('{8'h07, 8'ha5});
    run('{8'h04});
    chk("sleep", 9'h101, {deep_sleep, n_on[7:0]});
    reset_n_pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset_n_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("pin", {1'b0, 88'h0f00070105050000000000}, {deep_sleep, regs()});
    $display("test sleep done");
    bus_width_select <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run('{8'h00, 8'h00, 8'h00});
    chk("3-wire", 16'h0000, {panel_config, panel_vcom_float});
    $display("test 3-wire done");
    print_verdict();
  end
endmodule : tb_epaper_panel_command_decoder
